/* test/field_io_model.sv */
// Field-side model: isolated gate and clock pins of both counters
// Assumes the bench calls pulse() just after a rising edge of ref_clk
`timescale 1ns/1ps
module field_io_model (
   input wire logic ref_clk,
   input wire logic [1:0] gate_lvl,
   output logic iso_input_zero,
   output logic iso_input_one,
   output logic iso_input_two,
   output logic iso_input_three
);
   logic [1:0] clk_pin = 2'b00;
   assign iso_input_zero = gate_lvl[0];
   assign iso_input_two = gate_lvl[1];
   assign iso_input_one = clk_pin[0];
   assign iso_input_three = clk_pin[1];
   // Hold of at least one edge each way, else the synchroniser may miss it
   task automatic pulse(input int ch, input int hold);
      clk_pin[ch] <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      clk_pin[ch] <= 1'b0;
      repeat (hold) @(posedge ref_clk);
   endtask
endmodule

/* test/tb.sv */
// Self-checking bench of the counter routing block
// Assumes ctr_params.svh on the include path and field_io_model compiled first
`timescale 1ns/1ps
`include "ctr_params.svh"
module tb;
   import ctr_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat, v;
   logic pready, pslverr, rerr, irq, iso_output_two, iso_output_three;
   logic iso_input_zero, iso_input_one, iso_input_two, iso_input_three;
   logic [3:0] serial_activity = 4'h0;
   logic led_programmable_mode = 1'b0;
   logic [1:0] gate_lvl = 2'b00;
   logic [3:0] diagnostic_indicator;
   logic [11:0] a_flag = {`IDX_FLAG, 2'b00};
   logic [11:0] a_led = {`IDX_LED, 2'b00};
   logic [11:0] a_cnt [2] = '{{`IDX_CNT0, 2'b00}, {`IDX_CNT1, 2'b00}};
   logic [11:0] a_ctl [2] = '{{`IDX_CTL0, 2'b00}, {`IDX_CTL1, 2'b00}};
   logic [11:0] a_set [2] = '{{`IDX_SET0, 2'b00}, {`IDX_SET1, 2'b00}};
   int divs [4] = '{1000, 20, 40, 80};
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'hd7c8;
   int exp_cnt, k, w;

   always #5 ref_clk = ~ref_clk;

   // Small divisors keep the slow time bases inside the run
   counter_signal_routing #(.DIV_10K(20), .DIV_1K(40), .DIV_100(80)) u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .iso_input_zero(iso_input_zero),
      .iso_input_one(iso_input_one), .iso_input_two(iso_input_two),
      .iso_input_three(iso_input_three), .serial_activity(serial_activity),
      .led_programmable_mode(led_programmable_mode), .iso_output_two(iso_output_two),
      .iso_output_three(iso_output_three), .diagnostic_indicator(diagnostic_indicator),
      .irq(irq));
   field_io_model u_field (
      .ref_clk(ref_clk), .gate_lvl(gate_lvl), .iso_input_zero(iso_input_zero),
      .iso_input_one(iso_input_one), .iso_input_two(iso_input_two),
      .iso_input_three(iso_input_three));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) chk(1'b0, 1'b1, "no ready");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(rerr, 1'b0, "write error");
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
      apb(1'b0, a, 32'h0);
      chk(rdat, e, what);
   endtask

   task automatic run_ctr(input int ch, input logic pg);
      logic fl;
      logic [31:0] fb;
      fl = 1'b0;
      fb = 32'h1 << (`B_FLAG0 + ch);
      // Gate pin and soft bit disagree, so the wrong source shows
      gate_lvl[ch] <= ~pg;
      wr(a_set[ch], {28'h0, pg, pg, pg, 1'b1});
      wr(a_ctl[ch], {31'h0, pg});
      wr(a_cnt[ch], 32'h3);
      exp_cnt = 3;
      repeat (2) u_field.pulse(ch, 4);
      rd(a_cnt[ch], exp_cnt, "count with gate closed");
      gate_lvl[ch] <= 1'b1;
      wr(a_ctl[ch], 32'h1);
      repeat (3) @(posedge ref_clk);
      for (int n = 0; n < 4; n++) begin
         u_field.pulse(ch, 4 + n);
         exp_cnt = (exp_cnt == 1) ? 3 : exp_cnt - 1;
         if (exp_cnt == 1 && pg) fl = 1'b1;
         rd(a_cnt[ch], exp_cnt, "count");
         rd(a_ctl[ch], 32'h1 | ((exp_cnt == 1) << 4), "status");
         chk(ch ? iso_output_three : iso_output_two, pg && exp_cnt == 1, "route");
         rd(a_flag, fl ? fb : 32'h0, "flag");
         chk(irq, fl, "irq");
      end
      wr(a_flag, 32'h0);
      rd(a_flag, fl ? fb : 32'h0, "flag after zero write");
      wr(a_flag, fb);
      rd(a_flag, 32'h0, "flag after clear");
      chk(irq, 1'b0, "irq after clear");
      wr(a_ctl[ch], 32'h0);
      wr(a_set[ch], 32'h0);
      gate_lvl[ch] <= 1'b0;
      $display("test counter %0d gate_pin %0d done", ch, pg);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      chk(irq, 1'b0, "irq at reset");
      rd(a_flag, 32'h0, "flag reset");
      rd(a_led, 32'h0, "led reset");
      for (int c = 0; c < 2; c++) begin
         rd(a_cnt[c], 32'h0, "count reset");
         rd(a_ctl[c], 32'h0, "control reset");
         rd(a_set[c], 32'h0, "setting reset");
      end
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         led_programmable_mode <= 1'b1;
         wr(a_led, v);
         rd(a_led, {28'h0, v[3:0]}, "led register");
         repeat (5) @(posedge ref_clk);
         chk(diagnostic_indicator, v[3:0], "programmable leds");
         serial_activity <= v[7:4];
         led_programmable_mode <= 1'b0;
         repeat (5) @(posedge ref_clk);
         chk(diagnostic_indicator, v[7:4], "serial leds");
      end
      // Unmapped word and misaligned address must both be refused
      apb(1'b1, 12'h82c, ~v);
      chk(rerr, 1'b1, "unmapped refused");
      apb(1'b1, {`IDX_LED, 2'b10}, ~v);
      chk(rerr, 1'b1, "misaligned refused");
      rd(a_led, {28'h0, v[3:0]}, "led untouched");
      $display("test leds done");
      for (int i = 0; i < 4; i++) run_ctr(i % 2, i < 2);
      wr(a_set[0], 32'h1);
      wr(a_set[1], 32'h40);
      wr(a_ctl[0], 32'h1);
      wr(a_ctl[1], 32'h1);
      wr(a_cnt[0], 32'h2);
      wr(a_cnt[1], 32'h3);
      exp_cnt = 3;
      for (int n = 1; n <= 4; n++) begin
         u_field.pulse(0, 4);
         if (n % 2 == 0) exp_cnt--;
         rd(a_cnt[1], exp_cnt, "cascade high half");
      end
      wr(a_set[1], 32'h0);
      wr(a_set[0], 32'h0);
      wr(a_ctl[0], 32'h0);
      $display("test cascade done");
      wr(a_cnt[1], 32'h2);
      for (int s = 0; s < 4; s++) begin
         wr(a_set[1], 32'h4 | (s << 4));
         // Second pulse measured: the first may follow a partial prescale
         repeat (2) begin
            k = 0;
            while (iso_output_three !== 1'b1 && k < 3000) begin
               @(negedge ref_clk);
               k++;
            end
            w = 0;
            while (iso_output_three === 1'b1 && w < 3000) begin
               @(negedge ref_clk);
               w++;
            end
         end
         chk(w, divs[s], "time base width");
      end
      $display("test time base done");
      give_verdict();
   end
endmodule

/* verilog/counter_signal_routing.sv */
// Gate, clock and output routing, interrupt flags and LEDs of two counters
// Assumes an APB master on ref_clk and asynchronous field pins
// Function
// RULE1: Counters count only while gate active
// RULE2: Counter0 gate: soft bit or input zero
// RULE3: Counter1 gate: soft bit or input two
// RULE4: Counter0 output optionally drives output two
// RULE5: Counter1 output optionally drives output three
// RULE6: Flag reads one when interrupt occurred
// RULE7: Writing one clears flag, zero ignored
// RULE8: Software clears flag before next service
// RULE9: Per-counter interrupt enable, default off
// RULE10: Cascade bit joins counters into 32
// RULE11: LED register holds four enable bits
// RULE12: LEDs show serial activity unless programmable
// RULE13: Clock select: time base or inputs
// RULE14: Two-bit field picks time base rate
// RULE15: Each counter is 16-bit down counter
// RULE16: Output rising edge sets enabled flag
`timescale 1ns/1ps
`include "ctr_params.svh"
module counter_signal_routing
   import ctr_pkg::*;
#(
   parameter int DIV_10K = `DIV_TB1,
   parameter int DIV_1K = `DIV_TB2,
   parameter int DIV_100 = `DIV_TB3
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic iso_input_zero,
   input wire logic iso_input_one,
   input wire logic iso_input_two,
   input wire logic iso_input_three,
   input wire logic [3:0] serial_activity,
   input wire logic led_programmable_mode,
   output logic iso_output_two,
   output logic iso_output_three,
   output logic [3:0] diagnostic_indicator,
   output logic irq
);
   regs_t r_q;
   regs_t r_d;
   logic [`W_SYNC-1:0] syn;
   logic [9:0] idx;
   logic hit;
   logic wr;
   logic rd_setup;
   logic tb_tick;
   logic [1:0] ext_rise;
   logic tick0;
   logic tick1;
   logic gate0;
   logic gate1;
   logic load0;
   logic load1;
   logic [`W_CNT-1:0] count0;
   logic [`W_CNT-1:0] count1;
   logic [1:0] cnt_out;
   logic term0;
   logic term1;
   logic [1:0] rise;
   logic [1:0] irq_en;
   logic [1:0] clr;
   logic [`W_PRE-1:0] div_m1;
   logic cascade;

   // Word index of an aligned access
   function automatic logic [9:0] reg_index(input logic [11:0] a);
      return a[11:2];
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      logic [9:0] i;
      i = reg_index(a);
      return (a[1:0] == 2'h0) &&
         (i == `IDX_FLAG || i == `IDX_CNT0 || i == `IDX_CNT1 ||
          i == `IDX_CTL0 || i == `IDX_CTL1 || i == `IDX_SET0 ||
          i == `IDX_SET1 || i == `IDX_LED);
   endfunction

   input_sync u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pins({led_programmable_mode, serial_activity, iso_input_three,
             iso_input_two, iso_input_one, iso_input_zero}),
      .synced(syn)
   );

   assign idx = reg_index(paddr);
   assign hit = reg_hit(paddr);
   assign wr = psel & penable & pwrite & hit;
   assign rd_setup = psel & !penable & !pwrite;
   // Zero wait states; unmapped access answers with an error
   assign pready = psel & penable;
   assign pslverr = psel & penable & !hit;

   assign cascade = r_q.set1[`B_CASC];
   assign irq_en = {r_q.set1[`B_IRQEN], r_q.set0[`B_IRQEN]};
   assign tb_tick = r_q.pre_tick;
   // Edges are taken from the second sync stage only
   assign ext_rise = {syn[3], syn[1]} & ~r_q.ext_prev;

   // Clock sources [RULE13]
   assign tick0 = r_q.set0[`B_CLKSEL] ? ext_rise[0] : tb_tick;
   // Counter1 steps on counter0 terminal when cascaded [RULE10]
   assign tick1 = cascade ? term0 :
                  (r_q.set1[`B_CLKSEL] ? ext_rise[1] : tb_tick);
   assign gate0 = r_q.set0[`B_GATESEL] ? syn[0] : r_q.soft_gate[0]; // [RULE2]
   assign gate1 = r_q.set1[`B_GATESEL] ? syn[2] : r_q.soft_gate[1]; // [RULE3]
   assign load0 = wr & (idx == `IDX_CNT0);
   assign load1 = wr & (idx == `IDX_CNT1);

   down_counter u_cnt0 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .tick(tick0),
      .gate(gate0),
      .load(load0),
      .reload(pwdata[`W_CNT-1:0]),
      .count(count0),
      .out(cnt_out[0]),
      .term(term0)
   );

   down_counter u_cnt1 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .tick(tick1),
      .gate(gate1),
      .load(load1),
      .reload(pwdata[`W_CNT-1:0]),
      .count(count1),
      .out(cnt_out[1]),
      .term(term1)
   );

   // Time base divider select [RULE14]
   always_comb begin
      unique case ({r_q.set1[`B_TB_HI], r_q.set1[`B_TB_LO]})
         2'h0: div_m1 = `W_PRE'(`DIV_TB0 - 1);
         2'h1: div_m1 = `W_PRE'(DIV_10K - 1);
         2'h2: div_m1 = `W_PRE'(DIV_1K - 1);
         2'h3: div_m1 = `W_PRE'(DIV_100 - 1);
      endcase
   end

   assign rise = cnt_out & ~r_q.out_prev;
   assign clr = (wr && idx == `IDX_FLAG) ?
                {pwdata[`B_FLAG1], pwdata[`B_FLAG0]} : 2'h0;

   always_comb begin
      r_d = r_q;
      // Compare with >= so a faster rate never overruns the count
      if (r_q.pre_cnt >= div_m1) begin
         r_d.pre_cnt = '0;
         r_d.pre_tick = 1'b1;
      end else begin
         r_d.pre_cnt = r_q.pre_cnt + `W_PRE'(1);
         r_d.pre_tick = 1'b0;
      end
      r_d.ext_prev = {syn[3], syn[1]};
      r_d.out_prev = cnt_out;
      // Set wins over a clear in the same cycle [RULE16] [RULE7] [RULE9]
      r_d.flag = (rise & irq_en) | (r_q.flag & ~clr);
      if (wr) begin
         unique case (idx)
            `IDX_SET0: r_d.set0 = pwdata[`W_SET0-1:0];
            `IDX_SET1: r_d.set1 = pwdata[`W_SET1-1:0];
            `IDX_CTL0: r_d.soft_gate[0] = pwdata[`B_SOFTGATE];
            `IDX_CTL1: r_d.soft_gate[1] = pwdata[`B_SOFTGATE];
            `IDX_LED: r_d.led = pwdata[`W_LED-1:0]; // [RULE11]
            default: r_d.led = r_q.led;
         endcase
      end
      // Read data captured in setup, valid in access
      if (rd_setup) begin
         r_d.prdata = '0;
         unique case (idx)
            `IDX_FLAG: begin // [RULE6]
               r_d.prdata[`B_FLAG0] = r_q.flag[0];
               r_d.prdata[`B_FLAG1] = r_q.flag[1];
            end
            `IDX_CNT0: r_d.prdata[`W_CNT-1:0] = count0;
            `IDX_CNT1: r_d.prdata[`W_CNT-1:0] = count1;
            `IDX_CTL0: begin
               r_d.prdata[`B_SOFTGATE] = r_q.soft_gate[0];
               r_d.prdata[`B_OUTSTAT] = cnt_out[0];
            end
            `IDX_CTL1: begin
               r_d.prdata[`B_SOFTGATE] = r_q.soft_gate[1];
               r_d.prdata[`B_OUTSTAT] = cnt_out[1];
            end
            `IDX_SET0: r_d.prdata[`W_SET0-1:0] = r_q.set0;
            `IDX_SET1: r_d.prdata[`W_SET1-1:0] = r_q.set1;
            `IDX_LED: r_d.prdata[`W_LED-1:0] = r_q.led;
            default: r_d.prdata = '0;
         endcase
      end
      r_d.iso_out2 = r_q.set0[`B_OUTRT] & cnt_out[0]; // [RULE4]
      r_d.iso_out3 = r_q.set1[`B_OUTRT] & cnt_out[1]; // [RULE5]
      // Serial activity unless programmable mode [RULE12]
      r_d.led_pins = syn[8] ? r_q.led : syn[7:4];
      // Level request while an enabled flag stands [RULE16]
      r_d.irq = |(r_d.flag & irq_en);
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         r_q <= `RST_STATE;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.prdata;
   assign iso_output_two = r_q.iso_out2;
   assign iso_output_three = r_q.iso_out3;
   assign diagnostic_indicator = r_q.led_pins;
   assign irq = r_q.irq;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_gate_holds: assert property ( // [RULE1]
      !gate0 && !load0 |=> count0 == $past(count0))
      else $error("counter0 moved with gate low");
   a_soft_gate0: assert property ( // [RULE2]
      !r_q.set0[`B_GATESEL] && r_q.soft_gate[0] && tick0 && !load0 &&
      count0 > `CNT_TERM |=> count0 == $past(count0) - `CNT_TERM)
      else $error("soft gate did not enable counter0");
   a_soft_gate1: assert property ( // [RULE3]
      !r_q.set1[`B_GATESEL] && !r_q.soft_gate[1] && !load1
      |=> $stable(count1))
      else $error("counter1 moved with soft gate low");
   a_route_two: assert property ( // [RULE4]
      ##1 iso_output_two == ($past(r_q.set0[`B_OUTRT]) && $past(cnt_out[0])))
      else $error("output two routing wrong");
   a_route_three: assert property ( // [RULE5]
      ##1 iso_output_three == ($past(r_q.set1[`B_OUTRT]) && $past(cnt_out[1])))
      else $error("output three routing wrong");
   a_flag_read: assert property ( // [RULE6]
      rd_setup && idx == `IDX_FLAG |=> prdata[`B_FLAG0] == $past(r_q.flag[0]))
      else $error("flag read mismatch");
   a_flag_clear: assert property ( // [RULE7]
      wr && idx == `IDX_FLAG && pwdata[`B_FLAG0] && !(rise[0] && irq_en[0])
      |=> !r_q.flag[0])
      else $error("write one did not clear flag");
   a_flag_keep: assert property ( // [RULE7]
      wr && idx == `IDX_FLAG && !pwdata[`B_FLAG1] && r_q.flag[1]
      |=> r_q.flag[1])
      else $error("write zero changed flag");
   a_irq_disabled: assert property ( // [RULE9]
      !irq_en[0] && !r_q.flag[0] |=> !r_q.flag[0])
      else $error("disabled counter set flag");
   a_cascade_step: assert property ( // [RULE10]
      cascade && !term0 && !load1 |=> $stable(count1))
      else $error("cascaded counter1 moved without carry");
   a_led_write: assert property ( // [RULE11]
      wr && idx == `IDX_LED |=> r_q.led == $past(pwdata[`W_LED-1:0]))
      else $error("led register not written");
   a_led_mode: assert property ( // [RULE12]
      syn[8] |=> diagnostic_indicator == $past(r_q.led))
      else $error("programmable led not shown");
   a_ext_clock: assert property ( // [RULE13]
      r_q.set0[`B_CLKSEL] && !ext_rise[0] && !load0 |=> $stable(count0))
      else $error("counter0 moved without external edge");
   a_tb_period: assert property ( // [RULE14]
      r_q.pre_tick && $stable(div_m1) |-> $past(r_q.pre_cnt) >= div_m1)
      else $error("time base tick too early");
   a_reload: assert property ( // [RULE15]
      load0 |=> count0 == $past(pwdata[`W_CNT-1:0]))
      else $error("reload not taken");
   a_irq_raise: assert property ( // [RULE16]
      rise[0] && irq_en[0] |=> r_q.flag[0] && irq)
      else $error("enabled rise did not raise interrupt");

   // Pin gates freeze the count just like the soft bits
   a_pin_gate0: assert property ( // [RULE2]
      r_q.set0[`B_GATESEL] && !syn[0] && !load0 |=> $stable(count0))
      else $error("counter0 moved with gate pin low");
   a_pin_gate1: assert property ( // [RULE3]
      r_q.set1[`B_GATESEL] && !syn[2] && !load1 |=> $stable(count1))
      else $error("counter1 moved with gate pin low");
   // Unrouted outputs stay low, status only
   a_route_off2: assert property ( // [RULE4]
      !r_q.set0[`B_OUTRT] |=> !iso_output_two)
      else $error("output two driven while unrouted");
   a_route_off3: assert property ( // [RULE5]
      !r_q.set1[`B_OUTRT] |=> !iso_output_three)
      else $error("output three driven while unrouted");
   a_flag1_read: assert property ( // [RULE6]
      rd_setup && idx == `IDX_FLAG |=> prdata[`B_FLAG1] == $past(r_q.flag[1]))
      else $error("flag1 read mismatch");
   a_flag1_clear: assert property ( // [RULE7]
      wr && idx == `IDX_FLAG && pwdata[`B_FLAG1] && !(rise[1] && irq_en[1])
      |=> !r_q.flag[1])
      else $error("write one did not clear flag1");
   a_irq_masked: assert property ( // [RULE9]
      irq_en == 2'h0 |=> !irq)
      else $error("interrupt with both enables off");
   a_irq_off1: assert property ( // [RULE9]
      !irq_en[1] && !r_q.flag[1] |=> !r_q.flag[1])
      else $error("disabled counter1 set flag");
   // Carry from the low half steps the high half once
   a_cascade_carry: assert property ( // [RULE10]
      cascade && term0 && gate1 && !load1 && count1 > `CNT_TERM
      |=> count1 == $past(count1) - `CNT_TERM)
      else $error("cascaded counter1 missed carry");
   a_led_serial: assert property ( // [RULE12]
      !syn[8] |=> diagnostic_indicator == $past(syn[7:4]))
      else $error("serial activity not shown");
   a_ext_clock1: assert property ( // [RULE13]
      !cascade && r_q.set1[`B_CLKSEL] && !ext_rise[1] && !load1
      |=> $stable(count1))
      else $error("counter1 moved without external edge");
   a_tb_hold: assert property ( // [RULE14]
      !r_q.set0[`B_CLKSEL] && !tb_tick && !load0 |=> $stable(count0))
      else $error("counter0 moved between time base ticks");
   // Terminal reload uses the stored value, never the live bus
   a_term_reload: assert property ( // [RULE15]
      term0 |=> count0 == $past(u_cnt0.r_q.init))
      else $error("terminal reload wrong");
   a_irq_flag1: assert property ( // [RULE16]
      rise[1] && irq_en[1] |=> r_q.flag[1] && irq)
      else $error("enabled rise did not raise interrupt1");
   a_irq_needs: assert property ( // [RULE16]
      r_q.flag == 2'h0 |-> !irq)
      else $error("interrupt without a flag");

   c_flag0: cover property (r_q.flag[0] && irq);
   c_pin_gate: cover property (r_q.set1[`B_GATESEL] && gate1 && tick1);
   c_cascade: cover property (cascade && term1);
   c_route: cover property (r_q.set0[`B_OUTRT] && iso_output_two);
   c_clear: cover property (r_q.flag[1] ##1 !r_q.flag[1]);
endmodule

/* verilog/ctr_params.svh */
// Register indices, field positions, reset values and time bases
// Assumes inclusion by bare name from every design file that needs it
`ifndef CTR_PARAMS_SVH
`define CTR_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_FLAG 10'h207
`define IDX_CNT0 10'h208
`define IDX_CNT1 10'h209
`define IDX_CTL0 10'h20c
`define IDX_CTL1 10'h20d
`define IDX_SET0 10'h20e
`define IDX_SET1 10'h20f
`define IDX_LED 10'h212
// Setting register fields
`define B_CLKSEL 0
`define B_GATESEL 1
`define B_OUTRT 2
`define B_IRQEN 3
`define B_TB_LO 4
`define B_TB_HI 5
`define B_CASC 6
`define W_SET0 4
`define W_SET1 7
// Flag and start/status fields
`define B_FLAG0 2
`define B_FLAG1 3
`define B_SOFTGATE 0
`define B_OUTSTAT 4
`define W_LED 4
`define W_CNT 16
// Reset values
`define RST_STATE '0
`define RST_SYNC '0
`define RST_CNT '0
// Terminal count value of a down counter
`define CNT_TERM 16'h0001
// Clock and time bases in Hz
`define CLK_HZ 100000000
`define TB0_HZ 100000
`define TB1_HZ 10000
`define TB2_HZ 1000
`define TB3_HZ 100
`define DIV_TB0 (`CLK_HZ / `TB0_HZ)
`define DIV_TB1 (`CLK_HZ / `TB1_HZ)
`define DIV_TB2 (`CLK_HZ / `TB2_HZ)
`define DIV_TB3 (`CLK_HZ / `TB3_HZ)
`define W_PRE 20
`define W_SYNC 9
`endif

/* verilog/ctr_pkg.sv */
// State types of the counter routing block
// Assumes ctr_params.svh is on the include path
`include "ctr_params.svh"
package ctr_pkg;
   typedef struct packed {
      logic [`W_SYNC-1:0] s1;
      logic [`W_SYNC-1:0] s2;
   } sync_t;
   typedef struct packed {
      logic [`W_CNT-1:0] count;
      logic [`W_CNT-1:0] init;
      logic out;
   } dcnt_t;
   typedef struct packed {
      logic [1:0] flag;
      logic [1:0] soft_gate;
      logic [`W_SET0-1:0] set0;
      logic [`W_SET1-1:0] set1;
      logic [`W_LED-1:0] led;
      logic [1:0] out_prev;
      logic [1:0] ext_prev;
      logic [`W_PRE-1:0] pre_cnt;
      logic pre_tick;
      logic [`W_LED-1:0] led_pins;
      logic iso_out2;
      logic iso_out3;
      logic [31:0] prdata;
      logic irq;
   } regs_t;
endpackage

/* verilog/down_counter.sv */
// One 16-bit down counter with reload, gate and terminal pulse
// Assumes tick and gate come from ref_clk logic
`timescale 1ns/1ps
`include "ctr_params.svh"
module down_counter
   import ctr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic gate,
   input wire logic load,
   input wire logic [`W_CNT-1:0] reload,
   output logic [`W_CNT-1:0] count,
   output logic out,
   output logic term
);
   dcnt_t r_q;
   dcnt_t r_d;
   logic step;
   // Gate low freezes the count [RULE1]
   assign step = tick & gate & !load;
   assign term = step & (r_q.count == `CNT_TERM);
   always_comb begin
      r_d = r_q;
      if (load) begin
         r_d.count = reload;
         // Kept apart from the bus, which changes between writes
         r_d.init = reload;
      end else if (term) begin
         r_d.count = r_q.init;
      end else if (step) begin
         r_d.count = r_q.count - `CNT_TERM; // [RULE15]
      end
      // Output high while at terminal count
      r_d.out = (r_d.count == `CNT_TERM);
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         r_q <= `RST_CNT;
      end else begin
         r_q <= r_d;
      end
   end
   assign count = r_q.count;
   assign out = r_q.out;
endmodule

/* verilog/input_sync.sv */
// Two-stage synchroniser for the field-side pins
// Assumes the pins are asynchronous to ref_clk
`timescale 1ns/1ps
`include "ctr_params.svh"
module input_sync
   import ctr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [`W_SYNC-1:0] pins,
   output logic [`W_SYNC-1:0] synced
);
   sync_t r_q;
   sync_t r_d;
   always_comb begin
      r_d = r_q;
      r_d.s1 = pins;
      // First stage feeds only the second
      r_d.s2 = r_q.s1;
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         r_q <= `RST_SYNC;
      end else begin
         r_q <= r_d;
      end
   end
   assign synced = r_q.s2;
endmodule
